// *** rtl/mpp_ctrl.sv ***
// multiphase pwm phase selection, interleaving and power-state mode control
// assumes comparator and pin inputs are asynchronous; pulse pins are tri-state
`timescale 1ns/1ns
// What this block does
// - phase pin pulled high marks phase unused
// - phase count latched at enable, fixed
// - pulse pins drive high, low, or release
// - conduction enable high in states 00/01
// - conduction enable low in states 02/03
// - clock sets pulse, ramp comparator clears
// - phase clocks interleaved across period
// - transient fires all phases together in full state, ignored in light-load
// - state 0 fixed-frequency on all phases
// - other states single phase light-load
// - states 1-3 only phase 1 switches
// - voltage change forces full state
// - light-load pulses start at threshold
// - state 1 light-load keeps continuous conduction
// - two-bit state, 11 is ultra-low
// - alarm clearing returns to commanded state
// - current limit forces full-phase pulses
// - phase clock is master over count
// - threshold sets phase 1 pulse high
module mpp_ctrl #(
  parameter int DETECT_COUNT = mpp_pkg::DETECT_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic ENABLE,
  input wire logic MASTER_CLOCK_TICK,
  input wire logic [1:0] POWER_STATE,
  input wire logic VOLTAGE_CHANGE_FAST_CMD,
  input wire logic VOLTAGE_CHANGE_SLOW_CMD,
  input wire logic [3:0] RAMP_REACHED,
  input wire logic TRANSIENT_TRIGGER,
  input wire logic LIGHT_LOAD_THRESHOLD,
  input wire logic OVER_CURRENT_ALARM,
  input wire logic [3:0] PHASE_PIN_IN,
  output logic [3:0] PHASE_DRIVE_OUT,
  output logic [3:0] PHASE_DRIVE_OE,
  output logic CONTINUOUS_CONDUCTION_ENABLE,
  output logic ASYNC_LIGHT_LOAD_MODE,
  output logic [2:0] PHASE_COUNT,
  output logic RUNNING
);

  // detect counter is 16 bits wide
  if (DETECT_COUNT < 1 || DETECT_COUNT > 65535)
    $error("DETECT_COUNT out of range");

  // ----------------------------------------
  // input synchronisers: three flops, second and third agree
  // ----------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt;

  assign raw_in = {ENABLE, MASTER_CLOCK_TICK, TRANSIENT_TRIGGER, LIGHT_LOAD_THRESHOLD,
                   OVER_CURRENT_ALARM, VOLTAGE_CHANGE_FAST_CMD, VOLTAGE_CHANGE_SLOW_CMD,
                   POWER_STATE, RAMP_REACHED, PHASE_PIN_IN[3:1]};

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      filt <= '0;
    else
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
  end

  logic en_s;
  logic tick_s;
  logic trans_s;
  logic thr_s;
  logic oc_s;
  logic vfast_s;
  logic vslow_s;
  logic [1:0] ps_s;
  logic [3:0] ramp_s;
  logic [3:1] pin_s;
  assign {en_s, tick_s, trans_s, thr_s, oc_s, vfast_s, vslow_s, ps_s, ramp_s, pin_s} = filt;

  // ----------------------------------------
  // enable sequencing and phase detection
  // ----------------------------------------
  mpp_pkg::mpp_state_t state;
  logic [15:0] det_cnt;
  logic [3:0] active_set;
  logic [2:0] nphase;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      state <= mpp_pkg::MPP_IDLE;
      det_cnt <= 16'h0000;
    end
    else if (!en_s)
    begin
      state <= mpp_pkg::MPP_IDLE;
      det_cnt <= 16'h0000;
    end
    else
    begin
      unique case (state)
        mpp_pkg::MPP_IDLE:
        begin
          state <= mpp_pkg::MPP_DETECT;
          det_cnt <= 16'h0000;
        end
        mpp_pkg::MPP_DETECT:
        begin
          if (det_cnt == 16'(DETECT_COUNT - 1))
            state <= mpp_pkg::MPP_RUN;
          else
            det_cnt <= det_cnt + 16'h0001;
        end
        mpp_pkg::MPP_RUN:
          state <= mpp_pkg::MPP_RUN;
        default:
          state <= mpp_pkg::MPP_IDLE;
      endcase
    end
  end

  // phases past the first pulled-high pin are also dropped, so the set stays contiguous
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      active_set <= 4'h0;
      nphase <= 3'h0;
    end
    else if (!en_s)
    begin
      active_set <= 4'h0;
      nphase <= 3'h0;
    end
    else if (state == mpp_pkg::MPP_DETECT && det_cnt == 16'(DETECT_COUNT - 1))
    begin
      if (pin_s[1])
      begin
        active_set <= 4'h1;
        nphase <= 3'h1;
      end
      else if (pin_s[2])
      begin
        active_set <= 4'h3;
        nphase <= 3'h2;
      end
      else if (pin_s[3])
      begin
        active_set <= 4'h7;
        nphase <= 3'h3;
      end
      else
      begin
        active_set <= 4'hf;
        nphase <= 3'h4;
      end
    end
  end

  wire running = (state == mpp_pkg::MPP_RUN);

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  // voltage change, current limit force full-phase mode
  // once the alarm clears the commanded state takes over again
  wire force_full = vfast_s | vslow_s | oc_s;
  wire [1:0] eff_ps = force_full ? mpp_pkg::POWER_STATE_FULL : ps_s;
  wire light_load = (eff_ps != mpp_pkg::POWER_STATE_FULL);
  wire [3:0] enabled_set = light_load ? (active_set & 4'h1) : active_set;

  // ----------------------------------------
  // phase clock rotation
  // ----------------------------------------
  logic tick_d;
  logic [1:0] slot;
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      tick_d <= 1'b0;
    else
      tick_d <= tick_s;
  end
  wire tick_rise = tick_s & ~tick_d;

  // each master tick advances to the next phase: per-phase rate is master over count
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      slot <= 2'h0;
    else if (!running)
      slot <= 2'h0;
    else if (tick_rise)
    begin
      if ({1'b0, slot} >= nphase - 3'h1)
        slot <= 2'h0;
      else
        slot <= slot + 2'h1;
    end
  end

  logic thr_d;
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      thr_d <= 1'b0;
    else
      thr_d <= thr_s;
  end
  wire thr_rise = thr_s & ~thr_d;

  // ----------------------------------------
  // pulse set and clear
  // ----------------------------------------
  logic [3:0] pulse;
  logic [3:0] next_pulse;
  always_comb
  begin
    next_pulse = pulse;
    for (int i = 0; i < mpp_pkg::MAX_PHASES; i++)
    begin
      if (!running || !enabled_set[i])
        next_pulse[i] = 1'b0;
      else if (light_load)
      begin
        if (thr_rise)
          next_pulse[i] = 1'b1;
        else if (ramp_s[i])
          next_pulse[i] = 1'b0;
      end
      else if (trans_s)
        next_pulse[i] = ~ramp_s[i];
      else if (tick_rise && slot == 2'(i))
        next_pulse[i] = 1'b1;
      else if (ramp_s[i])
        next_pulse[i] = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      pulse <= 4'h0;
    else
      pulse <= next_pulse;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // used phases drive while running in full mode, only phase 1 in light-load; others are released to the middle level
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      PHASE_DRIVE_OUT <= 4'h0;
      PHASE_DRIVE_OE <= 4'h0;
    end
    else
    begin
      PHASE_DRIVE_OUT <= next_pulse;
      PHASE_DRIVE_OE <= (running && !light_load) ? active_set : (running ? (active_set & 4'h1) : 4'h0);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      CONTINUOUS_CONDUCTION_ENABLE <= 1'b1;
      ASYNC_LIGHT_LOAD_MODE <= 1'b0;
      PHASE_COUNT <= 3'h0;
      RUNNING <= 1'b0;
    end
    else
    begin
      CONTINUOUS_CONDUCTION_ENABLE <= (eff_ps == mpp_pkg::POWER_STATE_FULL) ||
                                      (eff_ps == mpp_pkg::POWER_STATE_LOW_CURRENT);
      ASYNC_LIGHT_LOAD_MODE <= running & light_load;
      PHASE_COUNT <= nphase;
      RUNNING <= running;
    end
  end

endmodule

// *** rtl/mpp_pkg.sv ***
// shared constants for the multiphase power-state pwm control block
// assumes one 20 MHz system clock and comparator inputs from the analog side
package mpp_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int DETECT_TIME_US = 50;
  localparam int DETECT_CYCLES = (DETECT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_PHASES = 4;
  // ----------------------------------------
  // power state encodings
  // ----------------------------------------
  localparam logic [1:0] POWER_STATE_FULL = 2'h0;
  localparam logic [1:0] POWER_STATE_LOW_CURRENT = 2'h1;
  localparam logic [1:0] POWER_STATE_SLEEP = 2'h2;
  localparam logic [1:0] POWER_STATE_ULTRA_LOW = 2'h3;
  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MPP_IDLE = 2'b00,
    MPP_DETECT = 2'b01,
    MPP_RUN = 2'b10
  } mpp_state_t;
endpackage

// *** testbench/mpp_ctrl_assertions.sv ***
// checker for the mpp_ctrl ports
// assumes binding to every mpp_ctrl instance
`timescale 1ns/1ns
module mpp_ctrl_assertions (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic ENABLE,
  input wire logic MASTER_CLOCK_TICK,
  input wire logic [1:0] POWER_STATE,
  input wire logic VOLTAGE_CHANGE_FAST_CMD,
  input wire logic VOLTAGE_CHANGE_SLOW_CMD,
  input wire logic [3:0] RAMP_REACHED,
  input wire logic TRANSIENT_TRIGGER,
  input wire logic LIGHT_LOAD_THRESHOLD,
  input wire logic OVER_CURRENT_ALARM,
  input wire logic [3:0] PHASE_PIN_IN,
  input wire logic [3:0] PHASE_DRIVE_OUT,
  input wire logic [3:0] PHASE_DRIVE_OE,
  input wire logic CONTINUOUS_CONDUCTION_ENABLE,
  input wire logic ASYNC_LIGHT_LOAD_MODE,
  input wire logic [2:0] PHASE_COUNT,
  input wire logic RUNNING
);
  // full state requested or forced
  wire full = POWER_STATE == 2'h0 || VOLTAGE_CHANGE_FAST_CMD || VOLTAGE_CHANGE_SLOW_CMD || OVER_CURRENT_ALARM;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  a_cce_high: assert property ((RUNNING && (full || POWER_STATE == 2'h1))[*8] |-> CONTINUOUS_CONDUCTION_ENABLE)
    else $error("cce low");
  a_cce_low: assert property ((RUNNING && !full && POWER_STATE[1])[*8] |-> !CONTINUOUS_CONDUCTION_ENABLE)
    else $error("cce high");
  a_mode_light: assert property ((RUNNING && !full)[*8] |-> ASYNC_LIGHT_LOAD_MODE)
    else $error("no light mode");
  a_mode_full: assert property ((RUNNING && full)[*8] |-> !ASYNC_LIGHT_LOAD_MODE)
    else $error("light mode while forced");
  a_count_fixed: assert property (RUNNING && $past(RUNNING) |-> $stable(PHASE_COUNT))
    else $error("count moved");
  a_unused_off: assert property (RUNNING |-> (PHASE_DRIVE_OE >> PHASE_COUNT) == 4'h0)
    else $error("unused phase driven");
  a_light_single: assert property (ASYNC_LIGHT_LOAD_MODE |-> PHASE_DRIVE_OUT[3:1] == 3'h0)
    else $error("extra phase in light mode");
  a_burst_all: assert property ((RUNNING && POWER_STATE == 2'h0 && TRANSIENT_TRIGGER && RAMP_REACHED == 4'h0)[*8]
    |-> PHASE_DRIVE_OUT == ~(4'hf << PHASE_COUNT))
    else $error("burst not on all phases");
endmodule
bind mpp_ctrl mpp_ctrl_assertions chk (
  .CLK_SYS(CLK_SYS),
  .RESET(RESET),
  .ENABLE(ENABLE),
  .MASTER_CLOCK_TICK(MASTER_CLOCK_TICK),
  .POWER_STATE(POWER_STATE),
  .VOLTAGE_CHANGE_FAST_CMD(VOLTAGE_CHANGE_FAST_CMD),
  .VOLTAGE_CHANGE_SLOW_CMD(VOLTAGE_CHANGE_SLOW_CMD),
  .RAMP_REACHED(RAMP_REACHED),
  .TRANSIENT_TRIGGER(TRANSIENT_TRIGGER),
  .LIGHT_LOAD_THRESHOLD(LIGHT_LOAD_THRESHOLD),
  .OVER_CURRENT_ALARM(OVER_CURRENT_ALARM),
  .PHASE_PIN_IN(PHASE_PIN_IN),
  .PHASE_DRIVE_OUT(PHASE_DRIVE_OUT),
  .PHASE_DRIVE_OE(PHASE_DRIVE_OE),
  .CONTINUOUS_CONDUCTION_ENABLE(CONTINUOUS_CONDUCTION_ENABLE),
  .ASYNC_LIGHT_LOAD_MODE(ASYNC_LIGHT_LOAD_MODE),
  .PHASE_COUNT(PHASE_COUNT),
  .RUNNING(RUNNING)
);

// *** testbench/mpp_stage_model.sv ***
// power stage stand-in: pin level seen by the controller
// assumes unused phases are strapped to the supply rail
`timescale 1ns/1ns
module mpp_stage_model (
  input wire logic [3:0] tied,
  input wire logic [3:0] drive,
  input wire logic [3:0] oe,
  output logic [3:0] pin
);
  // released pin sinks low unless strapped high
  assign pin = (oe & drive) | (~oe & tied);
endmodule

// *** testbench/testbench.sv ***
// bench for mpp_ctrl: power state table, then phase and pulse cases
// assumes mpp_stage_model for the power stages
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst = 1, en = 0, tick = 0, fst = 0, slw = 0, trn = 0, thr = 0, oc = 0, cce, aml, run;
  logic [1:0] ps = 2'h0;
  logic [3:0] ramp = 4'h0, tied = 4'h0, pin, out, oe;
  logic [2:0] cnt;
  int fail_count = 0, cmp_count = 0;
  // {state, fast, slow, alarm, cce, light}
  logic [6:0] rows [8] = '{7'h02, 7'h23, 7'h41, 7'h61, 7'h52, 7'h6a, 7'h46, 7'h41};
  // {strap mask, count}
  logic [7:0] det [5] = '{8'h04, 8'h83, 8'hc2, 8'he1, 8'h21};
  always #25 clk = ~clk;
  mpp_ctrl #(.DETECT_COUNT(4)) dut (.CLK_SYS(clk), .RESET(rst), .ENABLE(en), .MASTER_CLOCK_TICK(tick),
    .POWER_STATE(ps), .VOLTAGE_CHANGE_FAST_CMD(fst), .VOLTAGE_CHANGE_SLOW_CMD(slw), .RAMP_REACHED(ramp),
    .TRANSIENT_TRIGGER(trn), .LIGHT_LOAD_THRESHOLD(thr), .OVER_CURRENT_ALARM(oc), .PHASE_PIN_IN(pin),
    .PHASE_DRIVE_OUT(out), .PHASE_DRIVE_OE(oe), .CONTINUOUS_CONDUCTION_ENABLE(cce),
    .ASYNC_LIGHT_LOAD_MODE(aml), .PHASE_COUNT(cnt), .RUNNING(run));
  mpp_stage_model pwr (.tied(tied), .drive(out), .oe(oe), .pin(pin));
  task automatic chk(string what, logic [3:0] seen, logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start(logic [3:0] m);
    en <= 0;
    wt(8);
    tied <= m;
    en <= 1;
    for (int i = 0; i < 100 && run !== 1'b1; i++) wt(1);
    wt(2);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    wt(3);
    rst <= 0;
    start(4'h0);
    foreach (rows[i])
    begin
      {ps, fst, slw, oc} <= rows[i][6:2];
      wt(10);
      chk("cce", 4'(cce), 4'(rows[i][1]));
      chk("light", 4'(aml), 4'(rows[i][0]));
    end
    $display("table done");
    ps <= 2'h0;
    foreach (det[i])
    begin
      start(det[i][7:4]);
      chk("count", 4'(cnt), det[i][3:0]);
    end
    $display("detect test done");
    tied <= 4'h0;
    wt(10);
    chk("held count", 4'(cnt), 4'h1);
    start(4'h8);
    chk("oe", oe, 4'h7);
    for (int k = 0; k < 4; k++)
    begin
      tick <= 1;
      wt(8);
      chk("slot", out, 4'(1 << (k % 3)));
      tick <= 0;
      ramp <= 4'hf;
      wt(8);
      chk("clear", out, 4'h0);
      ramp <= 4'h0;
      wt(8);
    end
    $display("phase test done");
    trn <= 1;
    wt(8);
    chk("burst", out, 4'h7);
    ramp <= 4'hf;
    wt(8);
    chk("burst end", out, 4'h0);
    trn <= 0;
    ramp <= 4'h0;
    ps <= 2'h1;
    wt(10);
    thr <= 1;
    wt(8);
    chk("light pulse", out, 4'h1);
    chk("light oe", oe, 4'h1);
    thr <= 0;
    ramp <= 4'h1;
    wt(8);
    chk("light clear", out, 4'h0);
    ramp <= 4'h0;
    $display("pulse test done");
    rst <= 1;
    wt(2);
    chk("reset oe", oe, 4'h0);
    chk("reset count", 4'(cnt), 4'h0);
    chk("reset flags", {run, cce, aml, 1'b0}, 4'h4);
    $display("reset test done");
    give_verdict();
  end
endmodule
